/* logic/dac_pkg.sv */
// Purpose: Shared constants and carrier types for the converter code mapper.
// Assumes: APB with 32-bit data; register indices are word indices.
// Notes: Byte address of a register is four times its index.
`default_nettype none
package dac_pkg;
    localparam int unsigned ADDR_W       = 12;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned HOLD_W       = 8;
    localparam int unsigned CODE_W       = 10;
    localparam int unsigned CTRL_W       = 6;

    // Register indices; the bus address is index times four.
    localparam logic [ADDR_W-1:0] IDX_ANALOG_CONTROL  = 12'h0ef;
    localparam logic [ADDR_W-1:0] IDX_CONVERTER_HOLD  = 12'h0fa;
    localparam logic [ADDR_W-1:0] IDX_LADDER_STATUS   = 12'h0f0;
    localparam logic [ADDR_W-1:0] IDX_UPDATE_COUNT    = 12'h0f1;

    // Analog control field positions.
    localparam int unsigned CTRL_POWER_BIT      = 0;
    localparam int unsigned CTRL_HALF_BIT       = 3;
    localparam int unsigned CTRL_LOW_ZERO_BIT   = 4;
    localparam int unsigned CTRL_LOW_ONE_BIT    = 5;
    localparam int unsigned CTRL_GATE_BIT       = 7;

    // Status field positions.
    localparam int unsigned STAT_CODE_LSB       = 0;
    localparam int unsigned STAT_HALF_BIT       = 16;
    localparam int unsigned STAT_IDLE_BIT       = 17;
    localparam int unsigned STAT_REJECT_BIT     = 24;

    // Values after reset, the idle hold value and the update count width.
    localparam logic [CTRL_W-1:0] CTRL_RESET    = 6'h00;
    localparam logic [HOLD_W-1:0] HOLD_RESET    = 8'h00;
    localparam logic [CODE_W-1:0] CODE_RESET    = 10'h200;
    localparam logic [HOLD_W-1:0] HOLD_IDLE     = 8'h80;
    localparam int unsigned COUNT_W             = 16;

    typedef struct packed {
        logic                wr;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } apb_req_t;

    typedef struct packed {
        logic                half_scale_select;
        logic                low_code_bit_one;
        logic                low_code_bit_zero;
        logic [HOLD_W-1:0]   hold;
    } map_in_t;

    // Word index from a byte address; the two low bits select no register.
    function automatic logic [ADDR_W-1:0] word_index(input logic [ADDR_W-1:0] a);
        return {2'b00, a[ADDR_W-1:2]};
    endfunction
endpackage
`default_nettype wire

/* logic/apb_reg_port.sv */
// Purpose: APB slave front end with one registered ready per transfer.
// Assumes: Master holds the request until it samples pready high.
// Notes: Read data and error are captured in the setup cycle; refused reads return zero.
`timescale 1ns/1ps
`default_nettype none
module apb_reg_port (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [dac_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [dac_pkg::DATA_W-1:0]    pwdata,
    input  wire logic [dac_pkg::DATA_W-1:0]    rdata_in,
    input  wire logic                          addr_err,
    output logic                               pready,
    output logic [dac_pkg::DATA_W-1:0]         prdata,
    output logic                               pslverr,
    output dac_pkg::apb_req_t                  req
);
    logic setup;
    assign setup = psel & ~penable & ~pready;

    // Ready rises after the setup edge and falls after the completing edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= (pwrite || addr_err) ? '0 : rdata_in;
            pslverr <= addr_err;
        end
    end

    // A write takes effect only at the edge that completes the access.
    always_comb begin
        req.wr    = psel & penable & pready & pwrite & ~pslverr;
        req.addr  = paddr;
        req.wdata = pwdata;
    end
endmodule // apb_reg_port
`default_nettype wire

/* logic/ladder_code_map.sv */
// Purpose: Combinational map from hold and control bits to a ladder code.
// Assumes: Inputs come from registers on the same clock.
// Notes: Both modes produce offset binary from the signed hold value.
`timescale 1ns/1ps
`default_nettype none
module ladder_code_map (
    input  wire dac_pkg::map_in_t              map_in,
    output logic [dac_pkg::CODE_W-1:0]         code
);
    always_comb begin
        if (map_in.half_scale_select) begin
            code = {~map_in.hold[7], map_in.hold, map_in.low_code_bit_one};
        end else begin
            code = {~map_in.hold[7], map_in.hold[6:0],
                    map_in.low_code_bit_one, map_in.low_code_bit_zero};
        end
    end
endmodule // ladder_code_map
`default_nettype wire

/* logic/dac_code_mapper.sv */
// Purpose: Register front end and code mapping for a 10-bit resistor ladder.
// Assumes: APB master on pclk; ladder and amplifier sit outside this block.
// Notes: Control and hold are reachable at four times their word indices.
`timescale 1ns/1ps
`default_nettype none
module dac_code_mapper (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [dac_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [dac_pkg::DATA_W-1:0]    pwdata,
    output logic                               pready,
    output logic [dac_pkg::DATA_W-1:0]         prdata,
    output logic                               pslverr,
    output logic [dac_pkg::CODE_W-1:0]         ladder_code,
    output logic                               half_scale_active,
    output logic                               lowest_current_idle,
    output logic                               front_end_power
);
    dac_pkg::apb_req_t                 req;
    dac_pkg::map_in_t                  map_in;
    logic [dac_pkg::CTRL_W-1:0]        analog_control_q;
    logic [dac_pkg::HOLD_W-1:0]        converter_hold_q;
    logic [dac_pkg::CODE_W-1:0]        mapped_code;
    logic [dac_pkg::CODE_W-1:0]        ladder_code_q;
    logic                              half_q;
    logic                              idle_q;
    logic                              power_q;
    logic                              reject_q;
    logic                              apply_q;
    logic [dac_pkg::COUNT_W-1:0]       update_count_q;
    logic [dac_pkg::DATA_W-1:0]        rdata_mux;
    logic                              addr_err;
    logic [dac_pkg::ADDR_W-1:0]        rd_idx;
    logic [dac_pkg::ADDR_W-1:0]        wr_idx;
    logic                              wr_ctrl;
    logic                              wr_hold;
    logic                              wr_stat;
    logic                              ctrl_gated;

    apb_reg_port u_port (
        .pclk     (pclk),
        .presetn  (presetn),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .rdata_in (rdata_mux),
        .addr_err (addr_err),
        .pready   (pready),
        .prdata   (prdata),
        .pslverr  (pslverr),
        .req      (req)
    );

    // Unaligned addresses and unknown indices answer with an error.
    function automatic logic mapped_index(input logic [dac_pkg::ADDR_W-1:0] a);
        logic [dac_pkg::ADDR_W-1:0] i;
        i = dac_pkg::word_index(a);
        return (a[1:0] == 2'b00) &&
               (i == dac_pkg::IDX_ANALOG_CONTROL || i == dac_pkg::IDX_CONVERTER_HOLD ||
                i == dac_pkg::IDX_LADDER_STATUS  || i == dac_pkg::IDX_UPDATE_COUNT);
    endfunction

    assign rd_idx   = dac_pkg::word_index(paddr);
    assign wr_idx   = dac_pkg::word_index(req.addr);
    assign addr_err = ~mapped_index(paddr);

    always_comb begin
        rdata_mux = '0;
        case (rd_idx)
            dac_pkg::IDX_ANALOG_CONTROL: begin
                rdata_mux[dac_pkg::CTRL_W-1:0] = analog_control_q;
            end
            dac_pkg::IDX_CONVERTER_HOLD: begin
                rdata_mux[dac_pkg::HOLD_W-1:0] = converter_hold_q;
            end
            dac_pkg::IDX_LADDER_STATUS: begin
                rdata_mux[dac_pkg::STAT_CODE_LSB +: dac_pkg::CODE_W] = ladder_code_q;
                rdata_mux[dac_pkg::STAT_HALF_BIT]   = half_q;
                rdata_mux[dac_pkg::STAT_IDLE_BIT]   = idle_q;
                rdata_mux[dac_pkg::STAT_REJECT_BIT] = reject_q;
            end
            dac_pkg::IDX_UPDATE_COUNT: begin
                rdata_mux[dac_pkg::COUNT_W-1:0] = update_count_q;
            end
            default: begin
                rdata_mux = '0;
            end
        endcase
    end

    assign wr_ctrl    = req.wr && (wr_idx == dac_pkg::IDX_ANALOG_CONTROL);
    assign wr_hold    = req.wr && (wr_idx == dac_pkg::IDX_CONVERTER_HOLD);
    assign wr_stat    = req.wr && (wr_idx == dac_pkg::IDX_LADDER_STATUS);
    // The gate bit is active low: software must write it as zero to update.
    assign ctrl_gated = req.wdata[dac_pkg::CTRL_GATE_BIT];

    // Control bits keep their old value when the written gate bit is high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_control_q <= dac_pkg::CTRL_RESET;
        end else if (wr_ctrl && !ctrl_gated) begin
            analog_control_q <= req.wdata[dac_pkg::CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_hold_q <= dac_pkg::HOLD_RESET;
        end else if (wr_hold) begin
            converter_hold_q <= req.wdata[dac_pkg::HOLD_W-1:0];
        end
    end

    // A refused control write leaves a sticky mark; a new refusal wins over
    // a clear in the same cycle so that no event is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reject_q <= 1'b0;
        end else if (wr_ctrl && ctrl_gated) begin
            reject_q <= 1'b1;
        end else if (wr_stat && req.wdata[dac_pkg::STAT_REJECT_BIT]) begin
            reject_q <= 1'b0;
        end
    end

    // A completed hold write, or a control write with the gate bit low, schedules a refresh.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apply_q <= 1'b0;
        end else begin
            apply_q <= wr_hold | (wr_ctrl & ~ctrl_gated);
        end
    end

    always_comb begin
        map_in.half_scale_select = analog_control_q[dac_pkg::CTRL_HALF_BIT];
        map_in.low_code_bit_one  = analog_control_q[dac_pkg::CTRL_LOW_ONE_BIT];
        map_in.low_code_bit_zero = analog_control_q[dac_pkg::CTRL_LOW_ZERO_BIT];
        map_in.hold              = converter_hold_q;
    end

    ladder_code_map u_map (
        .map_in (map_in),
        .code   (mapped_code)
    );

    // The ladder only moves on a refresh, so it never sees half-written
    // state and stays steady between writes. The reset code is midscale.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ladder_code_q <= dac_pkg::CODE_RESET;
        end else if (apply_q) begin
            ladder_code_q <= mapped_code;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_q  <= 1'b0;
            idle_q  <= 1'b0;
            power_q <= 1'b0;
        end else if (apply_q) begin
            half_q  <= map_in.half_scale_select;
            // Lowest current follows hold 80H with both low bits clear.
            idle_q  <= (converter_hold_q == dac_pkg::HOLD_IDLE) &&
                       !map_in.low_code_bit_one && !map_in.low_code_bit_zero;
            power_q <= analog_control_q[dac_pkg::CTRL_POWER_BIT];
        end
    end

    // Counts ladder refreshes; wraps silently, software only compares values.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            update_count_q <= '0;
        end else if (apply_q) begin
            update_count_q <= update_count_q + 1'b1;
        end
    end

    assign ladder_code         = ladder_code_q;
    assign half_scale_active   = half_q;
    assign lowest_current_idle = idle_q;
    assign front_end_power     = power_q;
endmodule // dac_code_mapper
`default_nettype wire

/* tb/dac_ladder_model.sv */
// Purpose: Behavioural resistor ladder seen from the code input.
// Assumes: Code is offset binary with midscale at 200H.
// Notes: Level is in LSB steps; no settling time is modelled.
`timescale 1ns/1ps
`default_nettype none
module dac_ladder_model (
    input  wire logic [dac_pkg::CODE_W-1:0] ladder_code,
    output logic signed [10:0]              level,
    output logic                            at_rest
);
    // Midscale sits at 200H, so the level is the code less 512.
    assign level   = $signed({1'b0, ladder_code}) - 11'sd512;
    assign at_rest = (ladder_code == 10'h000);
endmodule // dac_ladder_model
`default_nettype wire

/* tb/dac_code_mapper_properties.sv */
// Purpose: Port-level checks of the ladder code mapper.
// Assumes: The code follows a completed write by two edges.
// Notes: The mapping checks key on the write that caused them; range, reset and steady checks do not.
`timescale 1ns/1ps
`default_nettype none
module dac_code_mapper_checker (
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [dac_pkg::ADDR_W-1:0]   paddr,
    input wire logic [dac_pkg::DATA_W-1:0]   pwdata,
    input wire logic                         pready,
    input wire logic [dac_pkg::DATA_W-1:0]   prdata,
    input wire logic                         pslverr,
    input wire logic [dac_pkg::CODE_W-1:0]   ladder_code,
    input wire logic                         half_scale_active,
    input wire logic                         lowest_current_idle,
    input wire logic                         front_end_power
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic done_w;
    logic wr_hold;
    logic wr_ctl;
    assign done_w  = psel && penable && pready && pwrite && !pslverr;
    assign wr_hold = done_w && (paddr == 12'h3e8);
    assign wr_ctl  = done_w && (paddr == 12'h3bc);
    full_upper_a: assert property (wr_hold ##2 !half_scale_active |->
        ladder_code[8:2] == $past(pwdata[6:0], 2)) else $error("full upper bits wrong");
    sign_invert_a: assert property (wr_hold |-> ##2
        ladder_code[9] == !$past(pwdata[7], 2)) else $error("sign bit not inverted");
    full_low_a: assert property (wr_ctl && !pwdata[7] && !pwdata[3] |-> ##2
        !half_scale_active && ladder_code[1:0] == $past(pwdata[5:4], 2))
        else $error("full low bits wrong");
    half_mid_a: assert property (wr_hold ##2 half_scale_active |->
        ladder_code[8:1] == $past(pwdata[7:0], 2)) else $error("half middle bits wrong");
    half_low_a: assert property (wr_ctl && !pwdata[7] && pwdata[3] |-> ##2
        half_scale_active && ladder_code[0] == $past(pwdata[5], 2))
        else $error("half low bit wrong");
    half_range_a: assert property (half_scale_active |->
        ladder_code inside {[10'h100:10'h2ff]}) else $error("half code out of range");
    reset_mid_a: assert property ($rose(presetn) |->
        ladder_code == 10'h200 && !half_scale_active) else $error("reset code not midscale");
    gated_write_a: assert property (wr_ctl && pwdata[7] |-> ##2
        $stable(ladder_code) [*3]) else $error("gated write moved code");
    code_steady_a: assert property (!$stable(ladder_code) |->
        $past(done_w, 2)) else $error("code changed without write");
    cover property (wr_hold ##2 half_scale_active);
    cover property (wr_ctl && pwdata[7]);
    cover property (lowest_current_idle && front_end_power);
endmodule // dac_code_mapper_checker
bind dac_code_mapper dac_code_mapper_checker i_dac_code_mapper_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ladder_code(ladder_code), .half_scale_active(half_scale_active),
    .lowest_current_idle(lowest_current_idle), .front_end_power(front_end_power));
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Directed scenarios for the ladder code mapper over APB.
// Assumes: Zero-wait slave; the code settles two edges after a write.
// Notes: Expected codes are literal table values, not computed by the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
    localparam logic [11:0] A_CTL  = 12'h3bc;
    localparam logic [11:0] A_HOLD = 12'h3e8;
    localparam logic [11:0] A_BAD  = 12'h3fc;
    localparam logic [11:0] A_STAT = 12'h3c0;
    localparam logic [11:0] A_CNT  = 12'h3c4;
    // Each entry: hold, control, code; control bit 3 picks half scale.
    localparam logic [31:0] MAP [14] = '{
        32'h8000_0000, 32'h8010_0001, 32'h8100_0004, 32'hff30_01ff, 32'h0000_0200,
        32'h7f20_03fe, 32'h7f30_03ff, 32'h8008_0100, 32'h8028_0101, 32'h8138_0103,
        32'hff28_01ff, 32'h0018_0200, 32'h7f28_02ff, 32'h0108_0202};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_s;
    logic half_scale_active, lowest_current_idle, front_end_power, at_rest;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_s;
    logic [9:0] ladder_code;
    logic signed [10:0] level;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    dac_code_mapper i_dac_code_mapper (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .ladder_code(ladder_code),
        .half_scale_active(half_scale_active), .lowest_current_idle(lowest_current_idle),
        .front_end_power(front_end_power));
    dac_ladder_model i_dac_ladder_model (.ladder_code(ladder_code), .level(level),
        .at_rest(at_rest));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) n_mismatch++;
        rd_s = prdata;
        err_s = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic t_reset;
        `CHK("code", 10'h200, ladder_code)
        xfer(1'b0, A_CTL, '0);
        `CHK("ctl", 32'h0, rd_s)
        xfer(1'b0, A_HOLD, '0);
        `CHK("hold", 32'h0, rd_s)
    endtask
    task automatic t_map;
        logic [31:0] e;
        for (int i = 0; i < 14; i++) begin
            e = MAP[i];
            xfer(1'b1, A_CTL, {24'h0, e[23:16]});
            xfer(1'b1, A_HOLD, {24'h0, e[31:24]});
            settle();
            `CHK("code", e[9:0], ladder_code)
            `CHK("half", e[19], half_scale_active)
        end
    endtask
    task automatic t_gate;
        xfer(1'b1, A_CTL, 32'hb7);
        `CHK("gate err", 1'b0, err_s)
        settle();
        `CHK("code", 10'h202, ladder_code)
        xfer(1'b0, A_CTL, '0);
        `CHK("ctl", 32'h08, rd_s)
        xfer(1'b0, A_STAT, '0);
        `CHK("stat", 32'h0101_0202, rd_s)
        xfer(1'b1, A_STAT, 32'h0100_0000);
        xfer(1'b0, A_STAT, '0);
        `CHK("stat clr", 32'h0001_0202, rd_s)
        xfer(1'b0, A_CNT, '0);
        `CHK("count", 32'h0000_001c, rd_s)
    endtask
    task automatic t_idle;
        xfer(1'b1, A_CTL, 32'h01);
        xfer(1'b1, A_HOLD, 32'h80);
        settle();
        `CHK("idle", 1'b1, lowest_current_idle)
        `CHK("power", 1'b1, front_end_power)
        `CHK("level", -11'sd512, level)
        `CHK("rest", 1'b1, at_rest)
    endtask
    task automatic t_bad;
        xfer(1'b1, A_BAD, 32'h7f);
        `CHK("bad err", 1'b1, err_s)
        settle();
        `CHK("code", 10'h000, ladder_code)
        xfer(1'b0, A_HOLD, '0);
        `CHK("hold", 32'h80, rd_s)
        xfer(1'b0, 12'h3bd, '0);
        `CHK("odd err", 1'b1, err_s)
        `CHK("odd data", 32'h0, rd_s)
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // A hung handshake must still reach the closing report.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        t_reset();
        t_map();
        t_gate();
        t_idle();
        t_bad();
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
